/* File: uepc_regs.vh */
// Purpose: register map and field positions of the endpoint control block
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes: all constants as macros
`ifndef UEPC_REGS_VH
`define UEPC_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define UEPC_IN_CTL_ADDR 4'h0
`define UEPC_OUT0_CTL_ADDR 4'h4
`define UEPC_IN_CFG_ADDR 4'h8
// ----------------------------------------
// field positions
// ----------------------------------------
`define UEPC_B_GO 31
`define UEPC_B_STOP 30
`define UEPC_B_ONE_CMD 29
`define UEPC_B_ZERO_CMD 28
`define UEPC_B_NAK_SET 27
`define UEPC_B_NAK_CLR 26
`define UEPC_B_STALL 21
`define UEPC_B_SNOOP 20
`define UEPC_B_NAKSTAT 17
`define UEPC_B_TOGGLE 16
`define UEPC_B_LIVE 15
`define UEPC_MPS_W 11
// ----------------------------------------
// transfer kinds and answers
// ----------------------------------------
`define UEPC_KIND_CTRL 2'h0
`define UEPC_KIND_ISO 2'h1
`define UEPC_HS_NONE 2'h0
`define UEPC_HS_ACK 2'h1
`define UEPC_HS_NAK 2'h2
`define UEPC_HS_STALL 2'h3
`define UEPC_RESP_OKAY 2'h0
`define UEPC_RESP_SLVERR 2'h2
`endif

/* File: uepc_endpoint_control.v */
// Purpose: IN endpoint-x and control OUT endpoint 0 control registers with link decisions
// Assumes: AXI4-Lite slave on ref_clk; link events are one-cycle pulses on ref_clk
// Notes: one write and one read at a time; 0x0 IN control, 0x4 ep0 OUT control, 0x8 IN config
//   hardware NAK set beats a software NAK clear, and a SETUP token beats a software STALL set
//   a hardware go clear beats a software go write; STALL is ignored by iso IN endpoints
//   command bits act only in enabled byte lanes and always read back as zero
//
// Summary of operation
// [R01] IN non-iso endpoint under NAK stops sending even with FIFO data pending.
// [R02] IN iso endpoint under NAK sends a zero-length packet.
// [R03] SETUP data packets are always acknowledged, NAK or not.
// [R04] bit 16 of IN register shows next data PID for bulk or interrupt.
// [R05] software sets the initial toggle with the set commands after enabling.
// [R06] bit 16 of iso IN endpoint shows frame parity, set by frame commands.
// [R07] USB bus reset clears the live bit of non-zero endpoints.
// [R08] software programs endpoint then sets live bit after configuration.
// [R09] bits 10..0 hold max payload bytes, reset zero.
// [R10] endpoint 0 OUT go bit set by software, cleared before its interrupts.
// [R11] endpoint 0 OUT stop bit is read-only zero.
// [R12] set-NAK command sets NAK; hardware sets it on completion or SETUP.
// [R13] clear-NAK command clears NAK.
// [R14] STALL set by software, cleared by SETUP token on endpoint 0.
// [R15] STALL beats endpoint NAK or global OUT NAK.
// [R16] SETUP data is accepted on endpoint 0 even while stalled.
// [R17] snoop mode passes OUT packets without correctness checks.
// [R18] endpoint 0 transfer kind is read-only zero, control.
// [R19] NAK state bit reads 1 while sending NAK handshakes; NAKs for empty non-iso IN FIFO, full ep0 FIFO or global OUT NAK leave it 0.
// [R20] write-only command bits act on a one and read as zero.
`timescale 1ns/1ps
`include "uepc_regs.vh"
module uepc_endpoint_control (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // axi4-lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // usb events
  input wire usb_bus_reset,
  input wire global_out_nak,
  // in endpoint token side
  input wire in_token,
  input wire in_fifo_has_data,
  output reg in_send_data,
  output reg in_send_zlp,
  output reg in_send_nak,
  output reg in_send_stall,
  output reg in_data_pid,
  input wire in_xfer_done,
  // endpoint 0 out token side
  input wire out0_setup_token,
  input wire out0_setup_data,
  input wire out0_data,
  input wire out0_fifo_space,
  input wire out0_xfer_done,
  output reg [1:0] out0_handshake,
  output reg out0_accept,
  output reg out0_skip_check,
  output reg out0_go_clear
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  // in endpoint-x fields
  reg in_nak_q;
  reg in_toggle_q;
  reg in_live_q;
  reg in_stall_q;
  reg [1:0] in_kind_q;
  reg [`UEPC_MPS_W-1:0] in_mps_q;

  // endpoint 0 out fields
  reg out0_go_q;
  reg out0_nak_q;
  reg out0_stall_q;
  reg out0_snoop_q;

  // write channel holding
  reg aw_hold_q;
  reg w_hold_q;
  reg [3:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  // word-aligned address match used by both read and write decode
  function hit;
    input [3:0] addr;
    input [3:0] reg_addr;
    begin
      hit = (addr[3:2] == reg_addr[3:2]);
    end
  endfunction

  // any of the three registers, shared by write response and read response
  function mapped;
    input [3:0] addr;
    begin
      mapped = hit(addr, `UEPC_IN_CTL_ADDR) || hit(addr, `UEPC_OUT0_CTL_ADDR) || hit(addr, `UEPC_IN_CFG_ADDR);
    end
  endfunction

  // answer to an IN token, one-hot {stall, data, zero-length, nak}; iso endpoints never stall
  function [3:0] in_answer;
    input iso;
    input stall;
    input nak;
    input has_data;
    begin
      in_answer = 4'h0;
      if (stall && !iso) begin
        in_answer[3] = 1'b1; // see [R15]
      end else if (!nak && has_data) begin
        in_answer[2] = 1'b1; // see [R01]
      end else if (iso) begin
        in_answer[1] = 1'b1; // see [R02]
      end else begin
        in_answer[0] = 1'b1; // see [R01] see [R19]
      end
    end
  endfunction

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire [3:0] wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_q ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_hold_q ? w_strb_q : s_axi_wstrb;
  wire wr_fire = (aw_hold_q || aw_take) && (w_hold_q || w_take);
  wire wr_in = wr_fire && hit(wr_addr, `UEPC_IN_CTL_ADDR);
  wire wr_o0 = wr_fire && hit(wr_addr, `UEPC_OUT0_CTL_ADDR);
  wire wr_cfg = wr_fire && hit(wr_addr, `UEPC_IN_CFG_ADDR);
  wire wr_ok = mapped(wr_addr);
  // per-lane command strobes: only ones with an enabled lane act
  wire [31:0] wmask;
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign wmask[lane*8 +: 8] = {8{wr_strb[lane]}};
    end
  endgenerate
  wire [31:0] wcmd = wr_data & wmask;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UEPC_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `UEPC_RESP_OKAY : `UEPC_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_hold_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (w_take) begin
          w_hold_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // in endpoint-x register
  // ----------------------------------------
  wire in_iso = (in_kind_q == `UEPC_KIND_ISO);
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_nak_q <= 1'b0;
      in_toggle_q <= 1'b0;
      in_live_q <= 1'b0;
      in_stall_q <= 1'b0;
      in_kind_q <= `UEPC_KIND_CTRL;
      in_mps_q <= 11'h000;
    end else begin
      // hardware set wins over software clear
      if (in_xfer_done) begin
        in_nak_q <= 1'b1;
      end else if (wr_in && wcmd[`UEPC_B_NAK_SET]) begin
        in_nak_q <= 1'b1;
      end else if (wr_in && wcmd[`UEPC_B_NAK_CLR]) begin
        in_nak_q <= 1'b0;
      end
      if (wr_in && wcmd[`UEPC_B_ONE_CMD]) begin
        in_toggle_q <= 1'b1; // see [R05] see [R06]
      end else if (wr_in && wcmd[`UEPC_B_ZERO_CMD]) begin
        in_toggle_q <= 1'b0; // see [R05] see [R06]
      end else if (in_send_data && !in_iso) begin
        in_toggle_q <= ~in_toggle_q; // see [R04]
      end
      if (usb_bus_reset) begin
        in_live_q <= 1'b0; // see [R07]
      end else if (wr_in && wr_strb[1]) begin
        in_live_q <= wr_data[`UEPC_B_LIVE]; // see [R08]
      end
      if (wr_in && wr_strb[2]) begin
        in_stall_q <= wr_data[`UEPC_B_STALL];
      end
      if (wr_cfg && wr_strb[0]) begin
        in_kind_q <= wr_data[1:0];
      end
      if (wr_in && wr_strb[0]) begin
        in_mps_q[7:0] <= wr_data[7:0]; // see [R09]
      end
      if (wr_in && wr_strb[1]) begin
        in_mps_q[10:8] <= wr_data[10:8]; // see [R09]
      end
    end
  end

  // ----------------------------------------
  // control out endpoint 0 register
  // ----------------------------------------
  wire o0_done = out0_xfer_done;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out0_go_q <= 1'b0;
      out0_nak_q <= 1'b0;
      out0_stall_q <= 1'b0;
      out0_snoop_q <= 1'b0;
    end else begin
      if (out0_setup_data || o0_done) begin
        out0_go_q <= 1'b0; // see [R10]
      end else if (wr_o0 && wcmd[`UEPC_B_GO]) begin
        out0_go_q <= 1'b1; // see [R10]
      end
      if (o0_done || out0_setup_data) begin
        out0_nak_q <= 1'b1; // see [R12]
      end else if (wr_o0 && wcmd[`UEPC_B_NAK_SET]) begin
        out0_nak_q <= 1'b1; // see [R12] see [R20]
      end else if (wr_o0 && wcmd[`UEPC_B_NAK_CLR]) begin
        out0_nak_q <= 1'b0; // see [R13] see [R20]
      end
      if (out0_setup_token) begin
        out0_stall_q <= 1'b0; // see [R14]
      end else if (wr_o0 && wcmd[`UEPC_B_STALL]) begin
        out0_stall_q <= 1'b1; // see [R14]
      end
      if (wr_o0 && wr_strb[2]) begin
        out0_snoop_q <= wr_data[`UEPC_B_SNOOP]; // see [R17]
      end
    end
  end

  // ----------------------------------------
  // in endpoint answers
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_send_data <= 1'b0;
      in_send_zlp <= 1'b0;
      in_send_nak <= 1'b0;
      in_send_stall <= 1'b0;
      in_data_pid <= 1'b0;
    end else begin
      {in_send_stall, in_send_data, in_send_zlp, in_send_nak} <= in_token ?
        in_answer(in_iso, in_stall_q, in_nak_q, in_fifo_has_data) : 4'h0; // see [R01] see [R02]
      in_data_pid <= in_toggle_q; // see [R04]
    end
  end

  // ----------------------------------------
  // endpoint 0 out answers
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out0_handshake <= `UEPC_HS_NONE;
      out0_accept <= 1'b0;
      out0_skip_check <= 1'b0;
      out0_go_clear <= 1'b0;
    end else begin
      out0_go_clear <= out0_setup_data || o0_done; // see [R10]
      out0_skip_check <= out0_snoop_q; // see [R17]
      if (out0_setup_data) begin
        out0_handshake <= `UEPC_HS_ACK; // see [R03] see [R16]
        out0_accept <= 1'b1; // see [R16]
      end else if (out0_data && out0_stall_q) begin
        out0_handshake <= `UEPC_HS_STALL; // see [R15]
        out0_accept <= 1'b0;
      end else if (out0_data && (out0_nak_q || global_out_nak || !out0_fifo_space)) begin
        out0_handshake <= `UEPC_HS_NAK; // see [R19]
        out0_accept <= 1'b0;
      end else if (out0_data) begin
        out0_handshake <= `UEPC_HS_ACK;
        out0_accept <= 1'b1;
      end else begin
        out0_handshake <= `UEPC_HS_NONE;
        out0_accept <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // register readback
  // ----------------------------------------
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h0000_0000;
    if (hit(s_axi_araddr, `UEPC_IN_CTL_ADDR)) begin
      rd_word[`UEPC_B_STALL] = in_stall_q;
      rd_word[19:18] = in_kind_q;
      rd_word[`UEPC_B_NAKSTAT] = in_nak_q; // see [R19]
      rd_word[`UEPC_B_TOGGLE] = in_toggle_q; // see [R04] see [R06]
      rd_word[`UEPC_B_LIVE] = in_live_q;
      rd_word[10:0] = in_mps_q; // see [R09]
    end else if (hit(s_axi_araddr, `UEPC_OUT0_CTL_ADDR)) begin
      // stop bit, transfer kind and commands stay zero
      rd_word[`UEPC_B_GO] = out0_go_q; // see [R11] see [R18] see [R20]
      rd_word[`UEPC_B_STALL] = out0_stall_q;
      rd_word[`UEPC_B_SNOOP] = out0_snoop_q;
      rd_word[`UEPC_B_NAKSTAT] = out0_nak_q; // see [R19]
      rd_word[`UEPC_B_LIVE] = 1'b1;
    end else if (hit(s_axi_araddr, `UEPC_IN_CFG_ADDR)) begin
      rd_word[1:0] = in_kind_q;
    end
  end
  wire rd_ok = mapped(s_axi_araddr);

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `UEPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? `UEPC_RESP_OKAY : `UEPC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* File: uepc_host.sv */
// Purpose: usb host stand-in for the link side
// Assumes: events are one-cycle pulses launched after a rising edge
// Notes: levels change only right after an edge
`timescale 1ns/1ps
module uepc_host (
  // clock
  input wire ref_clk,
  // token and packet events
  output wire in_token,
  output wire usb_bus_reset,
  output wire in_xfer_done,
  output wire out0_setup_token,
  output wire out0_setup_data,
  output wire out0_data,
  output wire out0_xfer_done,
  // levels
  output wire in_fifo_has_data,
  output wire global_out_nak,
  output wire out0_fifo_space
);
  logic [6:0] ev_q = 7'h00;
  logic [2:0] lv_q = 3'h0;
  assign {out0_xfer_done, out0_data, out0_setup_data, out0_setup_token} = ev_q[6:3];
  assign {in_xfer_done, usb_bus_reset, in_token} = ev_q[2:0];
  assign {out0_fifo_space, global_out_nak, in_fifo_has_data} = lv_q;
  task pulse(input int k);
    @(posedge ref_clk);
    ev_q <= 7'h01 << k;
    @(posedge ref_clk);
    ev_q <= 7'h00;
  endtask
  task levels(input logic [2:0] v);
    @(posedge ref_clk);
    lv_q <= v;
  endtask
endmodule

/* File: uepc_endpoint_control_properties.sv */
// Purpose: port checks of the endpoint control block
// Assumes: one clock, rst_n active low
// Notes: bound below the module
`timescale 1ns/1ps
`include "uepc_regs.vh"
module uepc_props (
  // clock, reset and bus
  input wire ref_clk,
  input wire rst_n,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_rvalid,
  input wire s_axi_arready,
  // link side
  input wire in_token,
  input wire in_send_data,
  input wire in_send_zlp,
  input wire in_send_nak,
  input wire in_send_stall,
  input wire global_out_nak,
  input wire out0_setup_data,
  input wire out0_data,
  input wire out0_xfer_done,
  input wire [1:0] out0_handshake,
  input wire out0_accept,
  input wire out0_go_clear
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready with rvalid");
  a_in_single: assert property (
    in_token |=> $onehot({in_send_data, in_send_zlp, in_send_nak, in_send_stall})) else $error("in answer");
  a_in_cause: assert property (
    in_send_data || in_send_zlp || in_send_nak || in_send_stall |-> $past(in_token)) else $error("in no token");
  a_setup_ack: assert property (
    out0_setup_data |=> out0_handshake == `UEPC_HS_ACK) else $error("setup not acked");
  a_go_clear: assert property (
    out0_setup_data || out0_xfer_done |=> out0_go_clear) else $error("go not cleared");
  a_stall_nak: assert property (
    out0_data && global_out_nak && !out0_setup_data |=> out0_handshake inside {`UEPC_HS_NAK, `UEPC_HS_STALL})
    else $error("global nak ignored");
  a_accept_ack: assert property (out0_accept |-> out0_handshake == `UEPC_HS_ACK) else $error("accept no ack");
endmodule
bind uepc_endpoint_control uepc_props uepc_props_i (.ref_clk, .rst_n, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_arready, .in_token, .in_send_data, .in_send_zlp, .in_send_nak, .in_send_stall,
  .global_out_nak, .out0_setup_data, .out0_data, .out0_xfer_done, .out0_handshake, .out0_accept, .out0_go_clear);

/* File: uepc_endpoint_control_bench.sv */
// Purpose: self-checking bench of the endpoint control block
// Assumes: 10 MHz ref_clk, host stand-in on the link side
// Notes: register words compared under a mask of defined bits
`timescale 1ns/1ps
`include "uepc_regs.vh"
module uepc_endpoint_control_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0000_0000, rv;
  logic [1:0] rs;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire [31:0] s_axi_rdata;
  wire [1:0] s_axi_bresp, s_axi_rresp, out0_handshake;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, in_send_data, in_send_zlp;
  wire in_send_nak, in_send_stall, in_data_pid, out0_accept, out0_skip_check, out0_go_clear, usb_bus_reset;
  wire global_out_nak, in_token, in_fifo_has_data, in_xfer_done, out0_setup_token, out0_setup_data;
  wire out0_data, out0_fifo_space, out0_xfer_done;
  int n_errors = 0, total_checks = 0;
  localparam logic [3:0] ad_in = `UEPC_IN_CTL_ADDR, ad_o0 = `UEPC_OUT0_CTL_ADDR, ad_cf = `UEPC_IN_CFG_ADDR;
  localparam logic [31:0] m_in = 32'h3c3f_87ff, m_o0 = 32'hcc3e_8000;
  uepc_endpoint_control uepc_endpoint_control_i (.*);
  uepc_host uepc_host_i (.*);
  initial forever #50 ref_clk = ~ref_clk;
  task report_and_stop;
    if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // one bus cycle, write when w is high
  task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    forever begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (w ? s_axi_bvalid : s_axi_rvalid) begin
        rs = w ? s_axi_bresp : s_axi_rresp;
        rv = s_axi_rdata;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task rdc(input string n, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(n, e, rv & m);
  endtask
  // event pulse, then stop mid-cycle while its one-cycle answer stands settled
  task ev(input int k);
    uepc_host_i.pulse(k);
    @(negedge ref_clk);
  endtask
  task t_in;
    rdc("in rst", ad_in, m_in, 32'h0000_0000);
    xfer(1'b1, ad_in, 32'hffff_ffff);
    rdc("in ones", ad_in, m_in, 32'h0023_87ff);
    xfer(1'b1, ad_in, 32'h0400_0000);
    rdc("in clr", ad_in, m_in, 32'h0001_0000);
    xfer(1'b1, ad_in, 32'h1000_0000);
    rdc("in d0", ad_in, m_in, 32'h0000_0000);
    uepc_host_i.levels(3'h1);
    ev(0);
    chk("in send", 32'h0000_0001, {in_data_pid, in_send_data});
    rdc("in d1", ad_in, m_in, 32'h0001_0000);
    ev(2);
    ev(0);
    chk("in nak", 32'h0000_0005, {in_data_pid, in_send_data, in_send_nak});
    rdc("in naks", ad_in, m_in, 32'h0003_0000);
    xfer(1'b1, ad_in, 32'h0020_0000);
    ev(0);
    chk("in stall", 32'h0000_0002, {in_send_stall, in_send_nak});
  endtask
  task t_iso;
    xfer(1'b1, ad_cf, 32'h0000_0001);
    xfer(1'b1, ad_in, 32'h2820_0000);
    rdc("iso odd", ad_in, m_in, 32'h0027_0000);
    ev(0);
    chk("iso zlp", 32'h0000_0001, {in_send_stall, in_send_data, in_send_zlp});
    xfer(1'b1, ad_in, 32'h1000_0000);
    rdc("iso even", ad_in, m_in, 32'h0006_0000);
    xfer(1'b1, ad_cf, 32'h0000_0000);
  endtask
  task t_live;
    xfer(1'b1, ad_in, 32'h0000_8000);
    ev(1);
    rdc("live", ad_in, 32'h0000_8000, 32'h0000_0000);
    rdc("ep0 live", ad_o0, 32'h0000_8000, 32'h0000_8000);
  endtask
  task t_ep0;
    rdc("ep0 rst", ad_o0, m_o0, 32'h0000_8000);
    uepc_host_i.levels(3'h2);
    xfer(1'b1, ad_o0, 32'hc030_0000);
    rdc("ep0 set", ad_o0, m_o0, 32'h8030_8000);
    ev(5);
    chk("ep0 stall", `UEPC_HS_STALL, out0_handshake);
    ev(4);
    chk("ep0 setup", {`UEPC_HS_ACK, 1'b1}, {out0_handshake, out0_go_clear});
    rdc("ep0 go", ad_o0, m_o0, 32'h0032_8000);
    ev(3);
    rdc("ep0 unstall", ad_o0, m_o0, 32'h0012_8000);
    xfer(1'b1, ad_o0, 32'h0410_0000);
    uepc_host_i.levels(3'h4);
    ev(5);
    chk("ep0 out", {`UEPC_HS_ACK, 2'h3}, {out0_handshake, out0_accept, out0_skip_check});
    uepc_host_i.levels(3'h6);
    ev(5);
    chk("ep0 gnak", `UEPC_HS_NAK, out0_handshake);
    ev(6);
    rdc("ep0 done", ad_o0, 32'h0002_0000, 32'h0002_0000);
  endtask
  task t_bad;
    xfer(1'b1, 4'hc, 32'hffff_ffff);
    chk("bad wr", `UEPC_RESP_SLVERR, rs);
    xfer(1'b0, 4'hc, 32'h0000_0000);
    chk("bad rd", {`UEPC_RESP_SLVERR, 30'h0000_0000}, {rs, rv[29:0]});
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_in();
    t_iso();
    t_live();
    t_ep0();
    t_bad();
    report_and_stop();
  end
  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end
endmodule
